/* design/ucpd_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef UCPD_REGS_SVH
`define UCPD_REGS_SVH

// Register offsets
`define UCPD_OFS_CTRL 8'h12
`define UCPD_OFS_PORT 8'h13
`define UCPD_OFS_FLAG 8'h14
`define UCPD_OFS_PUMP 8'h18

// Reset values
`define UCPD_RST_CTRL 8'hD0
`define UCPD_RST_PORT 8'h20
`define UCPD_RST_FLAG 8'h20
`define UCPD_RST_PUMP 8'h20

// Field positions
`define UCPD_BIT_FLOW_EN 7
`define UCPD_BIT_SYSRST_DIS 7
`define UCPD_BIT_PUMP_LVL 1
`define UCPD_BIT_PUMP_EN 0
`define UCPD_BIT_TO_SEL_HI 5
`define UCPD_BIT_TO_SEL_LO 4
`define UCPD_BIT_DCP_FLAG 2
`define UCPD_BIT_CDP_FLAG 1
`define UCPD_BIT_SDP_FLAG 0
`define UCPD_BIT_ST_HI 2
`define UCPD_BIT_ST_LO 0
`define UCPD_BIT_TO_EXP 1
`define UCPD_BIT_CHG_FOUND 0

// Writable masks (status bits read only)
`define UCPD_WMASK_CTRL 8'hF0
`define UCPD_WMASK_PORT 8'hE0
`define UCPD_WMASK_FLAG 8'hFC
`define UCPD_WMASK_PUMP 8'hFF

// Port status codes
`define UCPD_ST_NOBUS 3'h0
`define UCPD_ST_BUSY 3'h1
`define UCPD_ST_SDP 3'h2
`define UCPD_ST_NONSTANDARD_STANDARD_PORT 3'h3
`define UCPD_ST_DCP 3'h4
`define UCPD_ST_CDP 3'h5

// Contact-detect timeout base step in ms and clock rate in kHz
`define UCPD_TO_STEP_MS 300
`define UCPD_CLK_KHZ 125000
`define UCPD_TO_STEP_CYC (`UCPD_TO_STEP_MS * `UCPD_CLK_KHZ)

`endif

/* design/ucpd_pkg.sv */
// Types for the port detection register bank
package ucpd_pkg;

  // Outcome of the analog detection front end
  typedef struct packed {
    logic sdp;
    logic cdp;
    logic dcp;
  } ucpd_det_s;

  // Detection flow states, Gray coded along the usual path
  typedef enum logic [1:0] {
    UCPD_IDLE = 2'h0,
    UCPD_WAIT = 2'h1,
    UCPD_DONE = 2'h3
  } ucpd_state_e;

endpackage

/* design/ucpd_port_detect.sv */
// Register bank and detection sequencer for USB charger port-type detection
`timescale 1ns/100ps
`include "ucpd_regs.svh"

module ucpd_port_detect #(
  parameter int unsigned TO_STEP_CYC = `UCPD_TO_STEP_CYC
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Analog front end, asynchronous levels
  input wire logic vbus_present,
  input wire logic contact_detected,
  input wire ucpd_pkg::ucpd_det_s det_in,
  // Controls to analog
  output logic port_detect_flow_enable,
  output logic pump_enable,
  output logic pump_level_select,
  output logic system_reset_disable,
  output logic contact_timeout_expired,
  output logic charging_port_found
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] next_sync1;

  // Raw inputs gathered for the first stage
  always_comb begin
    next_sync1 = {vbus_present, contact_detected, det_in};
  end

  // Two-stage catch of the pin levels
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else if (clk_en) begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end

  logic vbus_s;
  logic contact_s;
  ucpd_pkg::ucpd_det_s det_s;
  assign vbus_s = sync2[4];
  assign contact_s = sync2[3];
  assign det_s = sync2[2:0];

  // ---------------------------------------------------------------
  // Writable register storage
  // ---------------------------------------------------------------
  logic [7:0] ctrl_w;
  logic [7:0] port_w;
  logic [7:0] flag_w;
  logic [7:0] pump_w;
  logic [7:0] next_ctrl_w;
  logic [7:0] next_port_w;
  logic [7:0] next_flag_w;
  logic [7:0] next_pump_w;

  // Writes touch only the writable bits of each register
  always_comb begin
    next_ctrl_w = ctrl_w;
    next_port_w = port_w;
    next_flag_w = flag_w;
    next_pump_w = pump_w;
    if (reg_wr) begin
      unique case (reg_addr)
        `UCPD_OFS_CTRL: next_ctrl_w = reg_wdata & `UCPD_WMASK_CTRL;
        `UCPD_OFS_PORT: next_port_w = reg_wdata & `UCPD_WMASK_PORT;
        `UCPD_OFS_FLAG: next_flag_w = reg_wdata & `UCPD_WMASK_FLAG;
        `UCPD_OFS_PUMP: next_pump_w = reg_wdata & `UCPD_WMASK_PUMP;
        default: ;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_w <= `UCPD_RST_CTRL;
      port_w <= `UCPD_RST_PORT;
      flag_w <= `UCPD_RST_FLAG;
      pump_w <= `UCPD_RST_PUMP;
    end else if (clk_en) begin
      ctrl_w <= next_ctrl_w;
      port_w <= next_port_w;
      flag_w <= next_flag_w;
      pump_w <= next_pump_w;
    end
  end

  logic flow_en;
  logic [1:0] to_sel;
  assign flow_en = ctrl_w[`UCPD_BIT_FLOW_EN];
  assign to_sel = ctrl_w[`UCPD_BIT_TO_SEL_HI:`UCPD_BIT_TO_SEL_LO];

  // ---------------------------------------------------------------
  // Detection sequencer
  // ---------------------------------------------------------------
  ucpd_pkg::ucpd_state_e state;
  ucpd_pkg::ucpd_state_e next_state;
  logic [31:0] to_cnt;
  logic [31:0] next_to_cnt;
  logic [31:0] to_limit;
  logic to_hit;
  logic next_to_hit;
  ucpd_pkg::ucpd_det_s found;
  ucpd_pkg::ucpd_det_s next_found;
  logic [2:0] status;
  logic [2:0] next_status;
  ucpd_pkg::ucpd_det_s pick;
  logic [2:0] pick_code;
  logic pick_any;

  // Port type pick, dedicated over downstream over standard
  always_comb begin
    pick = 3'h0;
    pick_code = `UCPD_ST_BUSY;
    pick_any = 1'b1;
    if (det_s.dcp) begin
      pick.dcp = 1'b1;
      pick_code = `UCPD_ST_DCP;
    end else if (det_s.cdp) begin
      pick.cdp = 1'b1;
      pick_code = `UCPD_ST_CDP;
    end else if (det_s.sdp) begin
      pick.sdp = 1'b1;
      pick_code = to_hit ? `UCPD_ST_NONSTANDARD_STANDARD_PORT : `UCPD_ST_SDP;
    end else begin
      pick_any = 1'b0;
    end
  end

  // Timeout is (sel + 1) steps of 300 ms
  always_comb begin
    to_limit = TO_STEP_CYC * ({30'h0, to_sel} + 32'h1);
  end

  // Sequencer: wait for contact or timeout, then latch the port type
  always_comb begin
    next_state = state;
    next_to_cnt = to_cnt;
    next_to_hit = to_hit;
    next_found = found;
    next_status = status;
    if (!vbus_s) begin
      next_state = ucpd_pkg::UCPD_IDLE;
      next_to_cnt = 32'h0;
      next_to_hit = 1'b0;
      next_found = 3'h0;
      next_status = `UCPD_ST_NOBUS;
    end else begin
      unique case (state)
        ucpd_pkg::UCPD_IDLE: begin
          if (flow_en) begin
            next_state = ucpd_pkg::UCPD_WAIT;
            next_to_cnt = 32'h0;
            next_status = `UCPD_ST_BUSY;
          end
        end
        ucpd_pkg::UCPD_WAIT: begin
          if (!flow_en) begin
            next_state = ucpd_pkg::UCPD_IDLE;
          end else if (contact_s || (to_cnt + 32'h1 >= to_limit)) begin
            next_to_hit = !contact_s;
            next_state = ucpd_pkg::UCPD_DONE;
          end else begin
            next_to_cnt = to_cnt + 32'h1;
          end
        end
        ucpd_pkg::UCPD_DONE: begin
          if (pick_any) begin
            next_found = pick;
            next_status = pick_code;
          end
        end
        default: next_state = ucpd_pkg::UCPD_IDLE;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ucpd_pkg::UCPD_IDLE;
      to_cnt <= 32'h0;
      to_hit <= 1'b0;
      found <= 3'h0;
      status <= `UCPD_ST_NOBUS;
    end else if (clk_en) begin
      state <= next_state;
      to_cnt <= next_to_cnt;
      to_hit <= next_to_hit;
      found <= next_found;
      status <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // Register views as software reads them
  // ---------------------------------------------------------------
  logic [7:0] ctrl_view;
  logic [7:0] port_view;
  logic [7:0] flag_view;
  logic [7:0] pump_view;

  // Read-only fields laid over stored bits, which stay zero there
  always_comb begin
    ctrl_view = ctrl_w;
    ctrl_view[`UCPD_BIT_DCP_FLAG] = found.dcp;
    ctrl_view[`UCPD_BIT_CDP_FLAG] = found.cdp;
    ctrl_view[`UCPD_BIT_SDP_FLAG] = found.sdp;
    port_view = port_w;
    port_view[`UCPD_BIT_ST_HI:`UCPD_BIT_ST_LO] = status;
    flag_view = flag_w;
    flag_view[`UCPD_BIT_TO_EXP] = to_hit;
    flag_view[`UCPD_BIT_CHG_FOUND] = found.dcp | found.cdp;
    pump_view = pump_w;
  end

  // ---------------------------------------------------------------
  // Read data and registered outputs
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;

  // Read mux picks one register view
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `UCPD_OFS_CTRL: next_rdata = ctrl_view;
        `UCPD_OFS_PORT: next_rdata = port_view;
        `UCPD_OFS_FLAG: next_rdata = flag_view;
        `UCPD_OFS_PUMP: next_rdata = pump_view;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  logic next_port_detect_flow_enable;
  logic next_pump_enable;
  logic next_pump_level_select;
  logic next_system_reset_disable;
  logic next_contact_timeout_expired;
  logic next_charging_port_found;

  // Outputs track the values stored at the same edge
  always_comb begin
    next_port_detect_flow_enable = next_ctrl_w[`UCPD_BIT_FLOW_EN];
    next_pump_enable = next_pump_w[`UCPD_BIT_PUMP_EN];
    next_pump_level_select = next_pump_w[`UCPD_BIT_PUMP_LVL];
    next_system_reset_disable = next_pump_w[`UCPD_BIT_SYSRST_DIS];
    next_contact_timeout_expired = next_to_hit;
    next_charging_port_found = next_found.dcp | next_found.cdp;
  end

  // Output flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      port_detect_flow_enable <= 1'b1;
      pump_enable <= 1'b0;
      pump_level_select <= 1'b0;
      system_reset_disable <= 1'b0;
      contact_timeout_expired <= 1'b0;
      charging_port_found <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
      port_detect_flow_enable <= next_port_detect_flow_enable;
      pump_enable <= next_pump_enable;
      pump_level_select <= next_pump_level_select;
      system_reset_disable <= next_system_reset_disable;
      contact_timeout_expired <= next_contact_timeout_expired;
      charging_port_found <= next_charging_port_found;
    end
  end

endmodule

/* test/ucpd_port_detect_props.sv */
// Concurrent checks on the port detection register bank ports
`timescale 1ns/100ps
module ucpd_port_detect_chk #(
  parameter int unsigned TO_STEP_CYC = 10
) (
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Front end and controls
  input wire logic vbus_present,
  input wire logic contact_detected,
  input wire ucpd_pkg::ucpd_det_s det_in,
  input wire logic port_detect_flow_enable,
  input wire logic pump_enable,
  input wire logic pump_level_select,
  input wire logic system_reset_disable,
  input wire logic contact_timeout_expired,
  input wire logic charging_port_found
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_rd_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_rd_unmapped: assert property (clk_en && reg_rd &&
    !(reg_addr inside {8'h12, 8'h13, 8'h14, 8'h18}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pump_write: assert property (clk_en && reg_wr && reg_addr == 8'h18 |=>
    {pump_level_select, pump_enable} == $past(reg_wdata[1:0])) else $error("pump bits");
  a_sysrst_write: assert property (clk_en && reg_wr && reg_addr == 8'h18 |=>
    system_reset_disable == $past(reg_wdata[7])) else $error("reset disable bit");
  a_flow_write: assert property (clk_en && reg_wr && reg_addr == 8'h12 |=>
    port_detect_flow_enable == $past(reg_wdata[7])) else $error("flow enable bit");
  a_flow_hold: assert property (!(clk_en && reg_wr && reg_addr == 8'h12) |=>
    $stable(port_detect_flow_enable)) else $error("flow enable moved");
  a_flag_read: assert property (clk_en && reg_rd && reg_addr == 8'h14 |=>
    reg_rdata[1:0] == $past({contact_timeout_expired, charging_port_found}))
    else $error("flag read mismatch");
  a_vbus_clear: assert property ((clk_en && !vbus_present) [*6] |->
    !charging_port_found && !contact_timeout_expired) else $error("flags kept");
  a_timeout_min: assert property (!vbus_present [*6] ##1 vbus_present |=>
    !contact_timeout_expired [*8]) else $error("timeout too early");
  c_pump: cover property (reg_wr && reg_addr == 8'h18 && reg_wdata[0]);
  c_found: cover property ($rose(charging_port_found));
  c_timeout: cover property ($rose(contact_timeout_expired));
endmodule
bind ucpd_port_detect ucpd_port_detect_chk #(.TO_STEP_CYC(TO_STEP_CYC)) chk_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .vbus_present(vbus_present), .contact_detected(contact_detected), .det_in(det_in),
  .port_detect_flow_enable(port_detect_flow_enable), .pump_enable(pump_enable),
  .pump_level_select(pump_level_select), .system_reset_disable(system_reset_disable),
  .contact_timeout_expired(contact_timeout_expired), .charging_port_found(charging_port_found));

/* test/ucpd_port_model.sv */
// Behavioural USB port as seen by the detection front end
`timescale 1ns/100ps
module ucpd_port_model (
  // Clock and scenario controls
  input wire logic clk_sys,
  input wire logic attach,
  input wire logic [1:0] kind,
  input wire logic contact_ok,
  // Lines toward the detector
  output logic vbus_present = 1'b0,
  output logic contact_detected = 1'b0,
  output ucpd_pkg::ucpd_det_s det_in = 3'h5
);
  // Compare lines show the port type while attached, churn otherwise
  always @(posedge clk_sys) begin
    vbus_present <= attach;
    contact_detected <= attach && contact_ok;
    det_in <= attach ? {kind == 2'h1, kind == 2'h2, kind == 2'h3} : ~det_in;
  end
endmodule

/* test/tb_ucpd_port_detect.sv */
// Self-checking bench for the port detection register bank
`timescale 1ns/100ps
`include "ucpd_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_ucpd_port_detect;
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
  logic attach = 1'b0, contact_ok = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [15:0] seed = 16'h02AD;
  localparam int unsigned STEP = 10;
  logic vbus_present, contact_detected, flow_en, pmp_en, pmp_lvl, rst_dis, to_exp, found;
  ucpd_pkg::ucpd_det_s det_in;
  int n_fail = 0, check_count = 0;
  logic [7:0] ofs [4] = '{`UCPD_OFS_CTRL, `UCPD_OFS_PORT, `UCPD_OFS_FLAG, `UCPD_OFS_PUMP};
  logic [7:0] rst [4] = '{`UCPD_RST_CTRL, `UCPD_RST_PORT, `UCPD_RST_FLAG, `UCPD_RST_PUMP};
  logic [7:0] msk [4] = '{`UCPD_WMASK_CTRL, `UCPD_WMASK_PORT, `UCPD_WMASK_FLAG, 8'hFF};
  logic [7:0] pv [3] = '{8'h81, 8'h03, 8'h00};
  ucpd_port_detect #(.TO_STEP_CYC(STEP)) ucpd_port_detect_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .vbus_present(vbus_present), .contact_detected(contact_detected), .det_in(det_in),
    .port_detect_flow_enable(flow_en), .pump_enable(pmp_en), .pump_level_select(pmp_lvl),
    .system_reset_disable(rst_dis), .contact_timeout_expired(to_exp), .charging_port_found(found));
  ucpd_port_model ucpd_port_model_inst (.clk_sys(clk_sys), .attach(attach), .kind(kind),
    .contact_ok(contact_ok), .vbus_present(vbus_present), .contact_detected(contact_detected),
    .det_in(det_in));
  // Clock at 125 MHz
  always #4 clk_sys = ~clk_sys;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Status code for kind 1 standard, 2 downstream charging, 3 dedicated
  function automatic logic [2:0] exp_code(input logic [1:0] k, input logic c);
    return k == 2'h3 ? 3'h4 : k == 2'h2 ? 3'h5 : (c ? 3'h2 : 3'h3);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Attach a port, check timeout timing, status and flags, then detach
  task automatic detect(input logic [1:0] k, input logic c, input logic [1:0] sel);
    wr(`UCPD_OFS_CTRL, {2'b11, sel, 4'h0});
    `CHK(flow_en, 1'b1)
    kind <= k;
    contact_ok <= c;
    attach <= 1'b1;
    // Model edge, two sync flops and the idle step precede the count
    repeat ((sel + 1) * STEP + 3) @(posedge clk_sys);
    #1;
    `CHK(to_exp, 1'b0)
    @(posedge clk_sys);
    #1;
    `CHK(to_exp, !c)
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK({to_exp, found}, {!c, k[1]})
    rd(`UCPD_OFS_PORT);
    `CHK(d[2:0], exp_code(k, c))
    rd(`UCPD_OFS_CTRL);
    `CHK(d[2:0], {k == 2'h3, k == 2'h2, k == 2'h1})
    rd(`UCPD_OFS_FLAG);
    `CHK(d[1:0], {!c, k[1]})
    attach <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(`UCPD_OFS_PORT);
    `CHK({d[2:0], to_exp, found}, 5'h00)
    $display("detect kind %0d contact %0d done", k, c);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #160000;
    n_fail++;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i]);
      `CHK(d, rst[i])
    end
    wr(8'h15, 8'hFF);
    rd(8'h15);
    `CHK(d, 8'h00)
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(ofs[i % 4], seed[7:0]);
      rd(ofs[i % 4]);
      `CHK(d, seed[7:0] & msk[i % 4])
    end
    foreach (pv[i]) begin
      wr(`UCPD_OFS_PUMP, pv[i]);
      `CHK({rst_dis, pmp_lvl, pmp_en}, {pv[i][7], pv[i][1:0]})
    end
    // A write made while the clock enable is low is lost
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(`UCPD_OFS_PUMP, 8'hFF);
    `CHK({rst_dis, pmp_lvl, pmp_en}, 3'h0)
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(`UCPD_OFS_PUMP);
    `CHK(d, 8'h00)
    $display("register writes done");
    detect(2'h1, 1'b1, 2'h1);
    for (int s = 0; s < 4; s++) detect(2'h1, 1'b0, s[1:0]);
    detect(2'h2, 1'b1, 2'h0);
    detect(2'h3, 1'b0, 2'h3);
    wr(`UCPD_OFS_CTRL, 8'h50);
    kind <= 2'h3;
    attach <= 1'b1;
    repeat (60) @(posedge clk_sys);
    rd(`UCPD_OFS_CTRL);
    `CHK({d[7], d[2:0], found, to_exp}, 6'h00)
    rd(`UCPD_OFS_PORT);
    `CHK(d[2:0], `UCPD_ST_NOBUS)
    $display("flow disabled done");
    test_done;
  end
endmodule
